// [dv/ladder_bit_logic_executor_bench.sv]
// bench: program scans through the executor against a queue reference
`timescale 1ns/100ps
`default_nettype none

module ladder_bit_logic_executor_bench;
    // ****************************************
    // signals
    // ****************************************
    logic             clk, rst;              // 100 MHz, synchronous reset
    logic             instr_valid, instr_bit;  // strobe and random device bit
    lbl_pkg::lbl_op_t instr_op, p_op;        // driven and program opcode
    logic [5:0]       instr_slot, p_slot;    // edge instance
    logic [2:0]       instr_level, p_level;  // region level
    logic [4:0]       pidx;                  // program step
    logic             result, region_enable, coil_valid, coil_value;
    logic             coil_hold, move_fire, seq_err;
    int               n_mismatch, compares;  // report counters
    logic [31:0]      rng;                   // xorshift state
    int               m_res, m_depth;        // reference result and depth
    int               m_en [9];              // enable per open depth
    int               m_prev [64];           // per-instance history
    int               pend [$], stk [$];     // pending branches, result stack
    int               e [7];                 // expected outputs
    bit               have;                  // e is live

    lbl_executor #(.SLOTS(64), .SLOT_W(6)) dut_u (
        .clk(clk), .rst(rst), .instr_valid(instr_valid), .instr_op(instr_op),
        .instr_bit(instr_bit), .instr_slot(instr_slot), .instr_level(instr_level),
        .result(result), .region_enable(region_enable), .coil_valid(coil_valid),
        .coil_value(coil_value), .coil_hold(coil_hold), .move_fire(move_fire),
        .seq_err(seq_err));
    lbl_prog_rom prog_u (.idx(pidx), .op(p_op), .slot(p_slot), .level(p_level));

    // free-running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] xs(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    // fixed-depth queues: zeros shift in, as in the store
    function automatic int qpop(ref int q[$]);
        int t;
        t = q.pop_front();
        q.push_back(0);
        return t;
    endfunction
    function automatic void qpush(ref int q[$], input int v);
        q.push_front(v);
        void'(q.pop_back());
    endfunction
    task automatic check(input logic seen, input int exp);
        compares++;
        if (seen !== 1'(exp)) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, 1'(exp));
        end
    endtask
    task automatic test_done();
        $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************
    // reference model of one instruction
    // ****************************************
    function automatic void model(input lbl_pkg::lbl_op_t op, input int b, s, l);
        int v;
        e[2] = 0;
        e[5] = 0;
        e[6] = 0;
        case (op)
            lbl_pkg::OP_LOAD_INVERTED_CONTACT, lbl_pkg::OP_SERIES_INVERTED_CONTACT,
            lbl_pkg::OP_PARALLEL_INVERTED_CONTACT: v = !b;
            lbl_pkg::OP_LOAD_RISING_EDGE, lbl_pkg::OP_SERIES_RISING_EDGE,
            lbl_pkg::OP_PARALLEL_RISING_EDGE: v = b & !m_prev[s];
            lbl_pkg::OP_LOAD_FALLING_EDGE, lbl_pkg::OP_SERIES_FALLING_EDGE,
            lbl_pkg::OP_PARALLEL_FALLING_EDGE: v = !b & m_prev[s];
            default: v = b;
        endcase
        if (op inside {[lbl_pkg::OP_LOAD_RISING_EDGE:lbl_pkg::OP_PARALLEL_FALLING_EDGE]})
            m_prev[s] = b;
        case (op)
            lbl_pkg::OP_LOAD_CONTACT, lbl_pkg::OP_LOAD_INVERTED_CONTACT,
            lbl_pkg::OP_LOAD_RISING_EDGE, lbl_pkg::OP_LOAD_FALLING_EDGE: begin
                qpush(pend, m_res);
                m_res = v;
            end
            lbl_pkg::OP_SERIES_CONTACT, lbl_pkg::OP_SERIES_INVERTED_CONTACT,
            lbl_pkg::OP_SERIES_RISING_EDGE, lbl_pkg::OP_SERIES_FALLING_EDGE: m_res &= v;
            lbl_pkg::OP_PARALLEL_CONTACT, lbl_pkg::OP_PARALLEL_INVERTED_CONTACT,
            lbl_pkg::OP_PARALLEL_RISING_EDGE, lbl_pkg::OP_PARALLEL_FALLING_EDGE: m_res |= v;
            lbl_pkg::OP_BLOCK_OR: m_res = m_res | qpop(pend);
            lbl_pkg::OP_BLOCK_AND: m_res = m_res & qpop(pend);
            lbl_pkg::OP_RESULT_PUSH: qpush(stk, m_res);
            lbl_pkg::OP_RESULT_PEEK: m_res = stk[0];
            lbl_pkg::OP_RESULT_POP: m_res = qpop(stk);
            lbl_pkg::OP_REGION_OPEN: begin
                e[6] = (l != m_depth);
                if (l == m_depth) m_en[m_depth + 1] = m_en[m_depth] & m_res;
                if (l == m_depth) m_depth++;
            end
            lbl_pkg::OP_REGION_CLOSE: begin
                e[6] = (l >= m_depth);
                if (l < m_depth) m_depth = l;
            end
            lbl_pkg::OP_COIL_OUT: begin
                e[2] = 1;
                e[3] = m_res & m_en[m_depth];
                e[4] = !m_en[m_depth];
            end
            lbl_pkg::OP_LEVEL_MOVE: e[5] = m_res & m_en[m_depth];
            lbl_pkg::OP_PULSE_MOVE: begin
                e[5] = m_res & !m_prev[s] & m_en[m_depth];
                m_prev[s] = m_res;
            end
            default: ;
        endcase
        e[0] = m_res;
        e[1] = m_en[m_depth];
    endfunction

    // one instruction per cycle; the previous one is judged at the falling edge
    task automatic exec(input lbl_pkg::lbl_op_t op, input int s, l);
        @(posedge clk);
        rng = xs(rng);
        instr_valid <= 1'b1;
        instr_op    <= op;
        instr_bit   <= rng[0];
        instr_slot  <= 6'(s);
        instr_level <= 3'(l);
        @(negedge clk);
        if (have) begin
            check(result, e[0]);
            check(region_enable, e[1]);
            check(coil_valid, e[2]);
            check(coil_value, e[3]);
            check(coil_hold, e[4]);
            check(move_fire, e[5]);
            check(seq_err, e[6]);
        end
        model(op, rng[0], s, l);
        have = 1'b1;
    endtask

    // bounded run
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        test_done();
    end

    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        instr_valid = 1'b0;
        instr_op = lbl_pkg::OP_NOP;
        instr_bit = 1'b0;
        instr_slot = 6'h00;
        instr_level = 3'h0;
        pidx = 5'h00;
        rng = 32'h0000_2933;
        n_mismatch = 0;
        compares = 0;
        m_res = 0;
        m_depth = 0;
        have = 1'b0;
        e = '{default: 0};
        m_en = '{default: 1};
        m_prev = '{default: 0};
        repeat (8) pend.push_back(0);
        repeat (8) stk.push_back(0);
        repeat (10) @(posedge clk);
        @(negedge clk);
        check(result, 0);
        check(region_enable, 1);
        @(posedge clk);
        rst <= 1'b0;
        // whole scans, random bits give edges of both kinds
        repeat (40) begin
            for (int i = 0; i < 30; i++) begin
                pidx = 5'(i);
                #1;
                exec(p_op, p_slot, p_level);
            end
        end
        // stack filled to its eight entries, then emptied
        for (int i = 0; i < 8; i++) begin
            exec(lbl_pkg::OP_LOAD_CONTACT, 0, 0);
            exec(lbl_pkg::OP_RESULT_PUSH, 0, 0);
        end
        repeat (8) exec(lbl_pkg::OP_RESULT_POP, 0, 0);
        // deepest nesting, then out-of-order levels that must be refused
        for (int i = 0; i < 8; i++) exec(lbl_pkg::OP_REGION_OPEN, 0, i);
        exec(lbl_pkg::OP_COIL_OUT, 0, 0);
        exec(lbl_pkg::OP_REGION_OPEN, 0, 7);
        exec(lbl_pkg::OP_REGION_CLOSE, 0, 7);
        exec(lbl_pkg::OP_REGION_CLOSE, 0, 7);
        exec(lbl_pkg::OP_REGION_CLOSE, 0, 0);
        exec(lbl_pkg::OP_REGION_OPEN, 0, 3);
        exec(lbl_pkg::OP_NOP, 0, 0);
        test_done();
    end
endmodule

`default_nettype wire

// [dv/lbl_prog_rom.sv]
// program model: one scan's instruction list, read by step
`timescale 1ns/100ps
`default_nettype none

module lbl_prog_rom (
    input  wire logic [4:0]       idx,    // step within the scan, 0..29
    output var  lbl_pkg::lbl_op_t op,     // instruction at that step
    output logic [5:0]            slot,   // one edge instance per step
    output logic [2:0]            level   // region level of open or close
);
    // ****************************************
    // program list
    // ****************************************
    localparam int N = 30;  // steps per scan
    // under eight pending loads per bus bar
    // pushes paired with later pops, two deep
    localparam lbl_pkg::lbl_op_t PROG [N] = '{
        lbl_pkg::OP_LOAD_CONTACT, lbl_pkg::OP_SERIES_CONTACT,
        lbl_pkg::OP_PARALLEL_INVERTED_CONTACT, lbl_pkg::OP_LOAD_INVERTED_CONTACT,
        lbl_pkg::OP_SERIES_INVERTED_CONTACT, lbl_pkg::OP_BLOCK_OR,
        lbl_pkg::OP_LOAD_RISING_EDGE, lbl_pkg::OP_PARALLEL_CONTACT,
        lbl_pkg::OP_BLOCK_AND, lbl_pkg::OP_RESULT_PUSH,
        lbl_pkg::OP_LOAD_FALLING_EDGE, lbl_pkg::OP_SERIES_RISING_EDGE,
        lbl_pkg::OP_PARALLEL_FALLING_EDGE, lbl_pkg::OP_RESULT_PUSH,
        lbl_pkg::OP_SERIES_FALLING_EDGE, lbl_pkg::OP_PARALLEL_RISING_EDGE,
        lbl_pkg::OP_RESULT_PEEK, lbl_pkg::OP_RESULT_POP,
        lbl_pkg::OP_REGION_OPEN, lbl_pkg::OP_LOAD_CONTACT,
        lbl_pkg::OP_REGION_OPEN, lbl_pkg::OP_COIL_OUT,
        lbl_pkg::OP_LEVEL_MOVE, lbl_pkg::OP_PULSE_MOVE,
        lbl_pkg::OP_REGION_CLOSE, lbl_pkg::OP_REGION_CLOSE,
        lbl_pkg::OP_RESULT_POP, lbl_pkg::OP_COIL_OUT,
        lbl_pkg::OP_NOP, lbl_pkg::OP_PULSE_MOVE
    };
    int open_n;  // regions still open before this step (opens minus closes)

    // ****************************************
    // read port; levels follow the open count
    // ****************************************
    always_comb begin
        op = PROG[idx];
        slot = 6'(idx);
        open_n = 0;
        for (int i = 0; i < N; i++) begin
            if (i < int'(idx) && PROG[i] == lbl_pkg::OP_REGION_OPEN) open_n++;
            if (i < int'(idx) && PROG[i] == lbl_pkg::OP_REGION_CLOSE) open_n--;
        end
        // opens ascend from zero, closes descend
        level = 3'(op == lbl_pkg::OP_REGION_CLOSE ? open_n - 1 : open_n);
    end
endmodule

`default_nettype wire

// [rtl/lbl_bit_stack.sv]
// one-bit push-down stack of configurable depth
`timescale 1ns/100ps
`default_nettype none

module lbl_bit_stack #(
    parameter int DEPTH = lbl_pkg::STACK_DEPTH
) (
    input  wire logic clk,
    input  wire logic rst,
    lbl_stk_if.store  s
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [DEPTH-1:0] ent;  // bit 0 is the top
    } lbl_stk_state_t;

    lbl_stk_state_t state_q;  // registered entries
    lbl_stk_state_t state_d;  // next entries

    generate
        if (DEPTH < 2) begin : g_bad_depth
            $error("stack depth below two");
        end
    endgenerate

    // shift register: a push beyond the depth drops the bottom entry
    always_comb begin
        state_d = state_q;
        if (s.push) begin
            state_d.ent = {state_q.ent[DEPTH-2:0], s.din};
        end else if (s.pop) begin
            state_d.ent = {1'b0, state_q.ent[DEPTH-1:1]};
        end
    end

    // entries clear at reset
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign s.top = state_q.ent[0];

endmodule

`default_nettype wire

// [rtl/lbl_edge_mem.sv]
// previous-value memory for edge contacts and pulse moves, one bit per instance
`timescale 1ns/100ps
`default_nettype none

module lbl_edge_mem #(
    parameter int SLOTS  = lbl_pkg::EDGE_SLOTS,
    parameter int SLOT_W = 6
) (
    input  wire logic clk,
    input  wire logic rst,
    lbl_edge_if.store e
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic [SLOTS-1:0] prev;  // value seen at the last run of each instance
    } lbl_edge_state_t;

    lbl_edge_state_t state_q;  // registered history
    lbl_edge_state_t state_d;  // next history

    generate
        if (SLOTS > (1 << SLOT_W) || SLOTS < 1) begin : g_bad_slots
            $error("slot count does not fit slot width");
        end
    endgenerate

    // compare against the instance's own history only
    assign e.rise = e.cur & ~state_q.prev[e.slot];
    assign e.fall = ~e.cur & state_q.prev[e.slot];

    // history is written only when its instance runs, so it spans one scan
    always_comb begin
        state_d = state_q;
        if (e.req) begin
            state_d.prev[e.slot] = e.cur;
        end
    end

    // a bit already on at reset reads as a rise on its first run
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q <= {SLOTS{lbl_pkg::EDGE_PREV_RST}};
        end else begin
            state_q <= state_d;
        end
    end

endmodule

`default_nettype wire

// [rtl/lbl_executor.sv]
// ladder bit-logic executor: one instruction per valid cycle on a one-bit result
//
// Summary of operation
// - load starts new result from bit
// - series contact ANDs bit into result
// - parallel contact ORs bit into result
// - block or merges branch with saved result
// - block and merges block with saved result
// - block instructions have no operand field
// - rising variants true one scan after off-on
// - falling variants true one scan after on-off
// - level move every scan, pulse move once
// - eight-entry one-bit intermediate result stack
// - push stores result, shifts entries down
// - pop restores top, shifts entries up
// - peek copies top, stack unchanged
// - enabled region executes its body normally
// - disabled region: coils off, retentive hold
// - open moves bus bar, close returns
// - levels ascend from zero, eight deep
`timescale 1ns/100ps
`default_nettype none

module lbl_executor #(
    parameter int SLOTS  = lbl_pkg::EDGE_SLOTS,
    parameter int SLOT_W = 6
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             instr_valid,
    input  wire lbl_pkg::lbl_op_t instr_op,
    input  wire logic             instr_bit,
    input  wire logic [SLOT_W-1:0] instr_slot,
    input  wire logic [lbl_pkg::LEVEL_W-1:0] instr_level,
    output logic                  result,
    output logic                  region_enable,
    output logic                  coil_valid,
    output logic                  coil_value,
    output logic                  coil_hold,
    output logic                  move_fire,
    output logic                  seq_err
);

    // ****************************************
    // state
    // ****************************************
    localparam int LV = lbl_pkg::REGION_LEVELS;

    typedef struct packed {
        logic          result;      // current logic result
        logic [LV-1:0] en;          // effective enable of each open level
        logic [3:0]    depth;       // open levels, 0..8
        logic          coil_valid;  // coil write pulse
        logic          coil_value;  // gated coil value
        logic          coil_hold;   // retentive elements must hold
        logic          move_fire;   // data move transfers this scan
        logic          seq_err;     // region level out of order
    } lbl_exec_state_t;

    lbl_exec_state_t state_q;  // registered state
    lbl_exec_state_t state_d;  // next state

    generate
        if (LV != 8) begin : g_bad_levels
            $error("depth counter sized for eight levels");
        end
    endgenerate

    // ****************************************
    // sub-blocks
    // ****************************************
    lbl_stk_if                  blk_s ();  // pending load branches
    lbl_stk_if                  res_s ();  // push/peek/pop results
    lbl_edge_if #(.SLOT_W(SLOT_W)) edg ();  // edge instance history

    // pending branches use the same stack shape as explicit pushes
    lbl_bit_stack #(.DEPTH(lbl_pkg::STACK_DEPTH)) u_blk_stack (
        .clk (clk),
        .rst (rst),
        .s   (blk_s.store)
    );

    lbl_bit_stack #(.DEPTH(lbl_pkg::STACK_DEPTH)) u_res_stack (
        .clk (clk),
        .rst (rst),
        .s   (res_s.store)
    );

    lbl_edge_mem #(.SLOTS(SLOTS), .SLOT_W(SLOT_W)) u_edge (
        .clk (clk),
        .rst (rst),
        .e   (edg.store)
    );

    // ****************************************
    // decode helpers
    // ****************************************
    // true for ops that consult the edge history
    function automatic logic uses_edge(input lbl_pkg::lbl_op_t op);
        uses_edge = op inside {[lbl_pkg::OP_LOAD_RISING_EDGE:
                                lbl_pkg::OP_PARALLEL_FALLING_EDGE], lbl_pkg::OP_PULSE_MOVE};
    endfunction

    // contact value: as is, complemented, or a one-scan edge
    function automatic logic operand(input lbl_pkg::lbl_op_t op, input logic b,
                                     input logic r, input logic f);
        case (op)
            lbl_pkg::OP_LOAD_INVERTED_CONTACT,
            lbl_pkg::OP_SERIES_INVERTED_CONTACT,
            lbl_pkg::OP_PARALLEL_INVERTED_CONTACT: operand = ~b;
            lbl_pkg::OP_LOAD_RISING_EDGE,
            lbl_pkg::OP_SERIES_RISING_EDGE,
            lbl_pkg::OP_PARALLEL_RISING_EDGE:      operand = r;
            lbl_pkg::OP_LOAD_FALLING_EDGE,
            lbl_pkg::OP_SERIES_FALLING_EDGE,
            lbl_pkg::OP_PARALLEL_FALLING_EDGE:     operand = f;
            default:                               operand = b;
        endcase
    endfunction

    logic opnd;     // operand value of this instruction
    logic cur_en;   // enable of the innermost open region

    assign opnd = operand(instr_op, instr_bit, edg.rise, edg.fall);
    // depth 8 wraps to index 7 through the 3-bit subtraction
    assign cur_en = (state_q.depth == 4'h0) ? 1'b1
                  : state_q.en[state_q.depth[2:0] - 3'h1];

    // history sees the contact bit, or the result for a pulse move
    assign edg.req  = instr_valid & uses_edge(instr_op);
    assign edg.slot = instr_slot;
    assign edg.cur  = (instr_op == lbl_pkg::OP_PULSE_MOVE) ? state_q.result : instr_bit;

    // ****************************************
    // instruction execution
    // ****************************************
    always_comb begin
        state_d            = state_q;
        state_d.coil_valid = 1'b0;
        state_d.move_fire  = 1'b0;
        state_d.seq_err    = 1'b0;
        blk_s.push = 1'b0;
        blk_s.pop  = 1'b0;
        blk_s.din  = state_q.result;
        res_s.push = 1'b0;
        res_s.pop  = 1'b0;
        res_s.din  = state_q.result;
        if (instr_valid) begin
            case (instr_op)
                // loads save the running result as a pending branch
                lbl_pkg::OP_LOAD_CONTACT, lbl_pkg::OP_LOAD_INVERTED_CONTACT,
                lbl_pkg::OP_LOAD_RISING_EDGE, lbl_pkg::OP_LOAD_FALLING_EDGE: begin
                    blk_s.push     = 1'b1;
                    state_d.result = opnd;
                end
                lbl_pkg::OP_SERIES_CONTACT, lbl_pkg::OP_SERIES_INVERTED_CONTACT,
                lbl_pkg::OP_SERIES_RISING_EDGE, lbl_pkg::OP_SERIES_FALLING_EDGE: begin
                    state_d.result = state_q.result & opnd;
                end
                lbl_pkg::OP_PARALLEL_CONTACT, lbl_pkg::OP_PARALLEL_INVERTED_CONTACT,
                lbl_pkg::OP_PARALLEL_RISING_EDGE, lbl_pkg::OP_PARALLEL_FALLING_EDGE: begin
                    state_d.result = state_q.result | opnd;
                end
                // operand fields are ignored for block ops
                lbl_pkg::OP_BLOCK_OR: begin
                    blk_s.pop      = 1'b1;
                    state_d.result = state_q.result | blk_s.top;
                end
                lbl_pkg::OP_BLOCK_AND: begin
                    blk_s.pop      = 1'b1;
                    state_d.result = state_q.result & blk_s.top;
                end
                lbl_pkg::OP_RESULT_PUSH: begin
                    res_s.push = 1'b1;
                end
                lbl_pkg::OP_RESULT_PEEK: begin
                    state_d.result = res_s.top;
                end
                lbl_pkg::OP_RESULT_POP: begin
                    res_s.pop      = 1'b1;
                    state_d.result = res_s.top;
                end
                // a level may only open at the next free depth
                lbl_pkg::OP_REGION_OPEN: begin
                    if ({1'b0, instr_level} == state_q.depth) begin
                        state_d.en[instr_level] = state_q.result & cur_en;
                        state_d.depth = state_q.depth + 4'h1;
                    end else begin
                        state_d.seq_err = 1'b1;
                    end
                end
                // closing a level also closes any deeper ones left open
                lbl_pkg::OP_REGION_CLOSE: begin
                    if ({1'b0, instr_level} < state_q.depth) begin
                        state_d.depth = {1'b0, instr_level};
                    end else begin
                        state_d.seq_err = 1'b1;
                    end
                end
                lbl_pkg::OP_COIL_OUT: begin
                    state_d.coil_valid = 1'b1;
                    state_d.coil_value = state_q.result & cur_en;
                    state_d.coil_hold  = ~cur_en;
                end
                lbl_pkg::OP_LEVEL_MOVE: begin
                    state_d.move_fire = state_q.result & cur_en;
                end
                lbl_pkg::OP_PULSE_MOVE: begin
                    state_d.move_fire = edg.rise & cur_en;
                end
                default: ;
            endcase
        end
    end

    // executor state registered here; stacks and edge history register in their sub-blocks
    always_ff @(posedge clk) begin
        if (rst) begin
            state_q        <= '0;
            state_q.result <= lbl_pkg::RESULT_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign result        = state_q.result;
    assign region_enable = cur_en;
    assign coil_valid    = state_q.coil_valid;
    assign coil_value    = state_q.coil_value;
    assign coil_hold     = state_q.coil_hold;
    assign move_fire     = state_q.move_fire;
    assign seq_err       = state_q.seq_err;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    lbl_pkg::lbl_op_t vop;  // opcode when valid, else no-op
    assign vop = instr_valid ? instr_op : lbl_pkg::OP_NOP;

    property p_load;
        vop == lbl_pkg::OP_LOAD_INVERTED_CONTACT |=> result == !$past(instr_bit);
    endproperty
    a_load: assert property (p_load) else $error("inverted load wrong");

    property p_series;
        vop == lbl_pkg::OP_SERIES_CONTACT
            |=> result == ($past(result) & $past(instr_bit));
    endproperty
    a_series: assert property (p_series) else $error("series wrong");

    property p_par;
        vop == lbl_pkg::OP_PARALLEL_INVERTED_CONTACT
            |=> result == ($past(result) | !$past(instr_bit));
    endproperty
    a_par: assert property (p_par) else $error("parallel wrong");

    property p_blk_or;
        vop == lbl_pkg::OP_LOAD_CONTACT ##1 vop == lbl_pkg::OP_BLOCK_OR
            |=> result == ($past(result, 2) | $past(result));
    endproperty
    a_blk_or: assert property (p_blk_or) else $error("block or wrong");

    property p_blk_and;
        vop == lbl_pkg::OP_LOAD_CONTACT ##1 vop == lbl_pkg::OP_BLOCK_AND
            |=> result == ($past(result, 2) & $past(result));
    endproperty
    a_blk_and: assert property (p_blk_and) else $error("block and wrong");

    property p_push_pop;
        vop == lbl_pkg::OP_RESULT_PUSH ##1 vop == lbl_pkg::OP_LOAD_CONTACT ##1
        vop == lbl_pkg::OP_RESULT_POP
            |=> result == $past(result, 3);
    endproperty
    a_push_pop: assert property (p_push_pop) else $error("pop lost value");

    property p_peek;
        vop == lbl_pkg::OP_RESULT_PEEK |=> result == $past(res_s.top) && $stable(res_s.top);
    endproperty
    a_peek: assert property (p_peek) else $error("peek moved stack");

    property p_coil_off;
        vop == lbl_pkg::OP_COIL_OUT && !region_enable
            |=> coil_valid && !coil_value && coil_hold;
    endproperty
    a_coil_off: assert property (p_coil_off) else $error("coil not forced off");

    property p_rise_once;
        vop == lbl_pkg::OP_LOAD_RISING_EDGE ##1 vop == lbl_pkg::OP_LOAD_RISING_EDGE
            && instr_slot == $past(instr_slot) && instr_bit && $past(instr_bit)
            |=> !result;
    endproperty
    a_rise_once: assert property (p_rise_once) else $error("edge held too long");

    property p_open;
        vop == lbl_pkg::OP_REGION_OPEN && state_q.depth == 4'h0
            && instr_level == 3'h0
            |=> state_q.depth == 4'h1 && region_enable == $past(result);
    endproperty
    a_open: assert property (p_open) else $error("region open wrong");

    property p_nest_err;
        vop == lbl_pkg::OP_REGION_OPEN && {1'b0, instr_level} != state_q.depth
            |=> seq_err && $stable(state_q.depth);
    endproperty
    a_nest_err: assert property (p_nest_err) else $error("out of order level taken");

endmodule

`default_nettype wire

// [rtl/lbl_if.sv]
// interfaces between the executor and its stack and edge memory
`timescale 1ns/100ps
`default_nettype none

// ****************************************
// one-bit stack access
// ****************************************
interface lbl_stk_if;
    logic push;   // place din on top, shift the rest down
    logic pop;    // drop the top, shift the rest up
    logic din;    // value to push
    logic top;    // current top entry
    modport user  (output push, output pop, output din, input top);
    modport store (input push, input pop, input din, output top);
endinterface

// ****************************************
// per-instance edge memory access
// ****************************************
interface lbl_edge_if #(parameter int SLOT_W = 6);
    logic              req;   // an edge instance runs this cycle
    logic [SLOT_W-1:0] slot;  // which instance
    logic              cur;   // present value of its bit
    logic              rise;  // off-to-on since its last run
    logic              fall;  // on-to-off since its last run
    modport user  (output req, output slot, output cur, input rise, input fall);
    modport store (input req, input slot, input cur, output rise, output fall);
endinterface

`default_nettype wire

// [rtl/lbl_pkg.sv]
// package: opcodes and constants of the ladder bit-logic executor
package lbl_pkg;

    // ****************************************
    // instruction opcodes
    // ****************************************
    typedef enum logic [4:0] {
        OP_NOP,
        OP_LOAD_CONTACT,
        OP_LOAD_INVERTED_CONTACT,
        OP_SERIES_CONTACT,
        OP_SERIES_INVERTED_CONTACT,
        OP_PARALLEL_CONTACT,
        OP_PARALLEL_INVERTED_CONTACT,
        OP_LOAD_RISING_EDGE,
        OP_LOAD_FALLING_EDGE,
        OP_SERIES_RISING_EDGE,
        OP_SERIES_FALLING_EDGE,
        OP_PARALLEL_RISING_EDGE,
        OP_PARALLEL_FALLING_EDGE,
        OP_BLOCK_OR,
        OP_BLOCK_AND,
        OP_RESULT_PUSH,
        OP_RESULT_PEEK,
        OP_RESULT_POP,
        OP_REGION_OPEN,
        OP_REGION_CLOSE,
        OP_COIL_OUT,
        OP_LEVEL_MOVE,
        OP_PULSE_MOVE
    } lbl_op_t;

    // ****************************************
    // sizes and reset values
    // ****************************************
    localparam int   STACK_DEPTH   = 8;     // intermediate result entries
    localparam int   REGION_LEVELS = 8;     // nesting levels 0..7
    localparam int   LEVEL_W       = 3;     // width of a region level number
    localparam int   EDGE_SLOTS    = 64;    // edge-contact instances kept
    localparam logic RESULT_RST    = 1'b0;  // result after reset
    localparam logic EDGE_PREV_RST = 1'b0;  // remembered bit after reset

endpackage
